// File: compressed_instruction_decoder.sv
`timescale 1ns/10ps
`default_nettype none
`include "cdec_defines.svh"
// What this block does
// - Expand each halfword into one full-width word
// - Register-offset load/store: 0101, bit9 clear
// - Immediate-offset load/store: 011, byte/load bits
// - Stack adjust: 10110000, sign, seven-bit magnitude
// - Long branch half: 1111, high/low, eleven bits
// - Adds from groups 5,12,13 keep flags
// - Moves from group 5 keep flags
// - Never encode features compressed forms lack
module compressed_instruction_decoder
   import cdec_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic in_valid,
   input wire logic [15:0] in_instr,
   output decode_out_t result
);

   // Data processing opcode for the compressed ALU group
   function automatic logic [3:0] alu_dp_opcode(input logic [3:0] op);
      logic [3:0] r;
      r = `DP_AND;
      case (op)
         4'h0: r = `DP_AND;
         4'h1: r = `DP_EOR;
         4'h5: r = `DP_ADC;
         4'h6: r = `DP_SBC;
         4'h8: r = `DP_TST;
         4'hA: r = `DP_CMP;
         4'hB: r = `DP_CMN;
         4'hC: r = `DP_ORR;
         4'hE: r = `DP_BIC;
         4'hF: r = `DP_MVN;
         default: r = `DP_MOV;
      endcase
      return r;
   endfunction

   // Data processing word with register or immediate second operand
   function automatic logic [31:0] dp_word(input logic imm, input logic [3:0] opc, input logic s,
                                           input logic [3:0] rn, input logic [3:0] rd,
                                           input logic [11:0] op2);
      return {`COND_ALWAYS, 2'b00, imm, opc, s, rn, rd, op2};
   endfunction

   // Field extraction; low registers zero-extend to four bits
   wire logic [15:0] h = in_instr;
   wire logic [3:0] dest_reg_field = {1'b0, h[2:0]};
   wire logic [3:0] source_reg_field = {1'b0, h[5:3]};
   wire logic [3:0] base_reg_field = {1'b0, h[5:3]};
   wire logic [3:0] offset_reg_field = {1'b0, h[8:6]};
   wire logic [3:0] upper_reg_field = {1'b0, h[10:8]};
   wire logic [4:0] five_bit_offset = h[10:6];
   wire logic [7:0] byte_field = h[7:0];
   wire logic [6:0] stack_adjust_magnitude = h[6:0];
   wire logic [10:0] eleven_bit_offset = h[10:0];
   wire logic [3:0] alu_op = h[9:6];
   wire logic [1:0] hi_op = h[9:8];
   wire logic [3:0] hi_dest = {h[7], h[2:0]};
   wire logic [3:0] hi_src = {h[6], h[5:3]};

   // Group classification by fixed upper bits, most specific first
   wire group_t group =
      (h[15:11] == 5'b00011) ? G_ADDSUB :
      (h[15:13] == 3'b000) ? G_SHIFT :
      (h[15:13] == 3'b001) ? G_IMM :
      (h[15:10] == 6'b010000) ? G_ALU :
      (h[15:10] == 6'b010001) ? G_HIREG :
      (h[15:11] == 5'b01001) ? G_PCLOAD :
      (h[15:12] == 4'b0101 && !h[9]) ? G_REGOFS :
      (h[15:12] == 4'b0101) ? G_SIGNED :
      (h[15:13] == 3'b011) ? G_IMMOFS :
      (h[15:12] == 4'b1000) ? G_HALF :
      (h[15:12] == 4'b1001) ? G_SPREL :
      (h[15:12] == 4'b1010) ? G_ADDR :
      (h[15:8] == 8'b10110000) ? G_SPADJ :
      (h[15:12] == 4'b1011 && h[10:9] == 2'b10) ? G_PUSHPOP :
      (h[15:12] == 4'b1100) ? G_MULTI :
      (h[15:8] == 8'b11011111) ? G_SWI :
      (h[15:12] == 4'b1101) ? G_BCOND :
      (h[15:11] == 5'b11100) ? G_BRANCH :
      (h[15:12] == 4'b1111) ? G_LONGBL :
      G_NONE;

   // Encodings that have no full-width counterpart are refused
   wire logic undefined = (group == G_NONE) ||
                          (group == G_BCOND && h[11:8] == `COND_UNDEF) ||
                          (group == G_HIREG && hi_op == 2'b11 && h[7]);

   // Shift type for the ALU register-shift forms
   wire logic [1:0] alu_shift_type = (alu_op == `ALU_LSL) ? 2'b00 :
                                     (alu_op == `ALU_LSR) ? 2'b01 :
                                     (alu_op == `ALU_ASR) ? 2'b10 : 2'b11;
   wire logic alu_is_shift = (alu_op == `ALU_LSL) || (alu_op == `ALU_LSR) ||
                             (alu_op == `ALU_ASR) || (alu_op == `ALU_ROR);
   wire logic alu_is_test = (alu_op == 4'h8) || (alu_op == 4'hA) || (alu_op == 4'hB);

   // Shift by immediate: flag-setting move of a shifted register
   wire logic [31:0] w_shift = {`COND_ALWAYS, 8'h1B, 4'h0, dest_reg_field, five_bit_offset, h[12:11], 1'b0,
                                source_reg_field};

   // Three-operand add or subtract, register or small immediate
   wire logic [31:0] w_addsub = dp_word(h[10], h[9] ? `DP_SUB : `DP_ADD, 1'b1, source_reg_field, dest_reg_field,
                                        {8'h00, offset_reg_field});

   // Move, compare, add or subtract with an eight-bit immediate
   wire logic [3:0] imm_opc = (h[12:11] == 2'b00) ? `DP_MOV :
                              (h[12:11] == 2'b01) ? `DP_CMP :
                              (h[12:11] == 2'b10) ? `DP_ADD : `DP_SUB;
   wire logic [31:0] w_imm = dp_word(1'b1, imm_opc, 1'b1, (h[12:11] == 2'b00) ? 4'h0 : upper_reg_field,
                                     (h[12:11] == 2'b01) ? 4'h0 : upper_reg_field, {4'h0, byte_field});

   // Register pair operations; register shifts and multiply are special
   wire logic [31:0] w_alu =
      (alu_op == `ALU_MUL) ? {`COND_ALWAYS, 8'h01, dest_reg_field, 4'h0, dest_reg_field, 4'h9, source_reg_field} :
      alu_is_shift ? {`COND_ALWAYS, 8'h1B, 4'h0, dest_reg_field, source_reg_field, 1'b0, alu_shift_type, 1'b1,
                      dest_reg_field} :
      (alu_op == `ALU_NEG) ? dp_word(1'b1, `DP_RSB, 1'b1, source_reg_field, dest_reg_field, 12'h000) :
      dp_word(1'b0, alu_dp_opcode(alu_op), 1'b1, (alu_op == 4'hF) ? 4'h0 : dest_reg_field,
              alu_is_test ? 4'h0 : dest_reg_field, {8'h00, source_reg_field});

   // High-register add, compare, move and branch-exchange
   wire logic [31:0] w_hireg =
      (hi_op == 2'b00) ? dp_word(1'b0, `DP_ADD, 1'b0, hi_dest, hi_dest, {8'h00, hi_src}) :
      (hi_op == 2'b01) ? dp_word(1'b0, `DP_CMP, 1'b1, hi_dest, 4'h0, {8'h00, hi_src}) :
      (hi_op == 2'b10) ? dp_word(1'b0, `DP_MOV, 1'b0, 4'h0, hi_dest, {8'h00, hi_src}) :
      (`BX_BASE | {28'h0000000, hi_src});

   // Word load relative to the program counter
   wire logic [31:0] w_pcload = {`COND_ALWAYS, 8'h59, `REG_PC, upper_reg_field, 2'b00, byte_field, 2'b00};

   // Load or store with a register offset
   wire logic [31:0] w_regofs = {`COND_ALWAYS, 3'b011, 1'b1, 1'b1, h[10], 1'b0, h[11], base_reg_field,
                                 dest_reg_field, 8'h00, offset_reg_field};

   // Sign-extending loads, the halfword load and the halfword store
   wire logic [31:0] w_signed = {`COND_ALWAYS, 3'b000, 1'b1, 1'b1, 1'b0, 1'b0, h[11] | h[10], base_reg_field,
                                 dest_reg_field, 4'h0, 1'b1, h[10], h[11] | ~h[10], 1'b1, offset_reg_field};

   // Load or store with five-bit offset; word offsets scaled by four
   wire logic [11:0] immofs_amount = h[12] ? {7'h00, five_bit_offset} : {5'h00, five_bit_offset, 2'b00};
   wire logic [31:0] w_immofs = {`COND_ALWAYS, 3'b010, 1'b1, 1'b1, h[12], 1'b0, h[11], base_reg_field,
                                 dest_reg_field, immofs_amount};

   // Halfword load or store, offset scaled by two
   wire logic [5:0] half_amount = {five_bit_offset, 1'b0};
   wire logic [31:0] w_half = {`COND_ALWAYS, 3'b000, 1'b1, 1'b1, 1'b1, 1'b0, h[11], base_reg_field,
                               dest_reg_field, 2'b00, half_amount[5:4], 4'hB, half_amount[3:0]};

   // Word load or store relative to the stack pointer
   wire logic [31:0] w_sprel = {`COND_ALWAYS, 4'h5, 2'b10, 1'b0, h[11], `REG_SP, upper_reg_field, 2'b00,
                                byte_field, 2'b00};

   // Address generation; flags left alone
   wire logic [31:0] w_addr = dp_word(1'b1, `DP_ADD, 1'b0, h[11] ? `REG_SP : `REG_PC, upper_reg_field,
                                      {`ROT_BY_FOUR, byte_field});

   // Stack pointer adjustment by a word-scaled magnitude; flags left alone
   wire logic [31:0] w_spadj = dp_word(1'b1, h[7] ? `DP_SUB : `DP_ADD, 1'b0, `REG_SP, `REG_SP,
                                       {`ROT_BY_FOUR, 1'b0, stack_adjust_magnitude});

   // Push and pop; bit 8 adds the return or link register
   wire logic [31:0] w_pushpop = h[11] ? {`POP_BASE, h[8], 7'h00, byte_field} :
                                         {`PUSH_BASE, 1'b0, h[8], 6'h00, byte_field};

   // Multiple load or store with base write-back; load bit lands at 20
   wire logic [31:0] w_multi = {`MULTI_BASE, upper_reg_field, 8'h00, byte_field} |
                               {11'h000, h[11], 20'h00000};

   // Conditional branch, offset sign-extended in halfwords
   wire logic [31:0] w_bcond = {h[11:8], 4'hA, {16{byte_field[7]}}, byte_field};

   // Software interrupt with its eight-bit comment value
   wire logic [31:0] w_swi = {`SWI_BASE, 8'h00, byte_field};

   // Unconditional branch, offset sign-extended in halfwords
   wire logic [31:0] w_branch = {`COND_ALWAYS, 4'hA, {13{eleven_bit_offset[10]}}, eleven_bit_offset};

   // Long branch half; the core pairs the two halves
   wire logic [31:0] w_longbl = {`COND_ALWAYS, 4'hB, 12'h000, h[11], eleven_bit_offset};

   // Select the expansion of the decoded group
   wire logic [31:0] next_expanded =
      undefined ? `NOP_WORD :
      (group == G_SHIFT) ? w_shift :
      (group == G_ADDSUB) ? w_addsub :
      (group == G_IMM) ? w_imm :
      (group == G_ALU) ? w_alu :
      (group == G_HIREG) ? w_hireg :
      (group == G_PCLOAD) ? w_pcload :
      (group == G_REGOFS) ? w_regofs :
      (group == G_SIGNED) ? w_signed :
      (group == G_IMMOFS) ? w_immofs :
      (group == G_HALF) ? w_half :
      (group == G_SPREL) ? w_sprel :
      (group == G_ADDR) ? w_addr :
      (group == G_SPADJ) ? w_spadj :
      (group == G_PUSHPOP) ? w_pushpop :
      (group == G_MULTI) ? w_multi :
      (group == G_BCOND) ? w_bcond :
      (group == G_SWI) ? w_swi :
      (group == G_BRANCH) ? w_branch :
      w_longbl;

   // Flag update: first four groups always, high-register group only compare
   wire logic next_flags_write = !undefined &&
      ((group == G_SHIFT) || (group == G_ADDSUB) || (group == G_IMM) || (group == G_ALU) ||
       (group == G_HIREG && hi_op == 2'b01));

   // Pipeline register toward the execution stage
   always_ff @(posedge clk) begin
      if (reset) begin
         result <= '{valid: 1'b0, group: G_NONE, expanded: 32'h00000000, flags_write: 1'b0, undefined: 1'b0};
      end else begin
         result <= '{valid: in_valid, group: group, expanded: next_expanded,
                     flags_write: in_valid & next_flags_write, undefined: in_valid & undefined};
      end
   end

endmodule
`default_nettype wire

// File: cdec_defines.svh
`ifndef CDEC_DEFINES_SVH
`define CDEC_DEFINES_SVH

// Condition field used for every unconditional expansion
`define COND_ALWAYS 4'hE
// Register numbers of the stack pointer and program counter
`define REG_SP 4'hD
`define REG_PC 4'hF
// Rotate field that scales an 8-bit immediate by four
`define ROT_BY_FOUR 4'hF
// Full-width data processing opcodes
`define DP_AND 4'h0
`define DP_EOR 4'h1
`define DP_SUB 4'h2
`define DP_RSB 4'h3
`define DP_ADD 4'h4
`define DP_ADC 4'h5
`define DP_SBC 4'h6
`define DP_TST 4'h8
`define DP_CMP 4'hA
`define DP_CMN 4'hB
`define DP_ORR 4'hC
`define DP_MOV 4'hD
`define DP_BIC 4'hE
`define DP_MVN 4'hF
// Compressed ALU group opcodes that are not plain data processing
`define ALU_LSL 4'h2
`define ALU_LSR 4'h3
`define ALU_ASR 4'h4
`define ALU_ROR 4'h7
`define ALU_NEG 4'h9
`define ALU_MUL 4'hD
// Fixed upper bits of full-width words; only BX_BASE is a whole word
`define BX_BASE 32'hE12FFF10
`define PUSH_BASE 16'hE92D
`define POP_BASE 16'hE8BD
`define MULTI_BASE 12'hE8A
`define SWI_BASE 16'hEF00
// Branch condition code that is undefined in the compressed set
`define COND_UNDEF 4'hE
// Word emitted for an undefined halfword (move r0 to r0)
`define NOP_WORD 32'hE1A00000

`endif

// File: cdec_pkg.sv
package cdec_pkg;

   // Format group of a compressed halfword
   typedef enum logic [4:0] {
      G_NONE = 5'h00, G_SHIFT = 5'h01, G_ADDSUB = 5'h02, G_IMM = 5'h03,
      G_ALU = 5'h04, G_HIREG = 5'h05, G_PCLOAD = 5'h06, G_REGOFS = 5'h07,
      G_SIGNED = 5'h08, G_IMMOFS = 5'h09, G_HALF = 5'h0A, G_SPREL = 5'h0B,
      G_ADDR = 5'h0C, G_SPADJ = 5'h0D, G_PUSHPOP = 5'h0E, G_MULTI = 5'h0F,
      G_BCOND = 5'h10, G_SWI = 5'h11, G_BRANCH = 5'h12, G_LONGBL = 5'h13
   } group_t;

   // Registered result handed to the execution pipeline
   typedef struct packed {
      logic valid;
      group_t group;
      logic [31:0] expanded;
      logic flags_write;
      logic undefined;
   } decode_out_t;

endpackage

// File: compressed_instruction_decoder_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module decoder_monitor
   import cdec_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic in_valid,
   input wire logic [15:0] in_instr,
   input wire decode_out_t result
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Valid halfword taken on a live edge
   sequence fed(hit);
      !reset && in_valid && hit;
   endsequence
   valid_delay_a: assert property (!reset |=> result.valid == $past(in_valid))
      else $error("valid not delayed by one edge");
   regofs_fields_a: assert property (fed(in_instr[15:12] == 4'h5 && !in_instr[9]) |=> result.group == G_REGOFS
      && result.expanded[22:20] == {$past(in_instr[10]), 1'b0, $past(in_instr[11])}
      && result.expanded[3:0] == {1'b0, $past(in_instr[8:6])}) else $error("register offset fields wrong");
   immofs_fields_a: assert property (fed(in_instr[15:13] == 3'b011) |=> result.group == G_IMMOFS
      && result.expanded[22:12] == {$past(in_instr[12]), 1'b0, $past(in_instr[11]), 1'b0, $past(in_instr[5:3]),
      1'b0, $past(in_instr[2:0])}) else $error("immediate offset fields wrong");
   spadj_word_a: assert property (fed(in_instr[15:8] == 8'hB0) |=> result.expanded ==
      {8'hE2, $past(in_instr[7]) ? 4'h4 : 4'h8, 12'hDDF, 1'b0, $past(in_instr[6:0])}) else $error("stack adjust wrong");
   longbl_half_a: assert property (fed(in_instr[15:12] == 4'hF) |=> result.group == G_LONGBL
      && result.expanded[31:24] == 8'hEB && result.expanded[11:0] == $past(in_instr[11:0])) else $error("long half wrong");
   add_keeps_flags_a: assert property (fed(in_instr[15:12] == 4'hA || in_instr[15:8] == 8'hB0
      || in_instr[15:8] == 8'h44) |=> !result.flags_write) else $error("add wrote flags");
   mov_keeps_flags_a: assert property (fed(in_instr[15:8] == 8'h46) |=> !result.flags_write)
      else $error("high move wrote flags");
   low_sets_flags_a: assert property (fed(in_instr[15:10] <= 6'h10) |=> result.flags_write)
      else $error("flags not written");
   undef_nop_a: assert property (fed(in_instr[15:11] == 5'h1D) |=> result.undefined
      && result.expanded == 32'hE1A00000) else $error("undefined not flagged");
endmodule
bind compressed_instruction_decoder decoder_monitor i_decoder_monitor(.clk(clk), .reset(reset), .in_valid(in_valid),
   .in_instr(in_instr), .result(result));
`default_nettype wire

// File: fetch_model.sv
`timescale 1ns/10ps
`default_nettype none
module fetch_model (
   input wire logic clk,
   input wire logic req_valid,
   input wire logic [15:0] req_word,
   output var logic in_valid = 1'b0,
   output var logic [15:0] in_instr = 16'h0000
);
   // Hand over on the falling edge; idle slots carry scrambled bits
   always @(negedge clk) begin
      in_valid <= req_valid;
      in_instr <= req_valid ? req_word : ~in_instr;
   end
endmodule
`default_nettype wire

// File: compressed_instruction_decoder_tb.sv
`timescale 1ns/10ps
`default_nettype none
module compressed_instruction_decoder_tb
   import cdec_pkg::*;
;
   logic clk, reset, req_valid, in_valid, fw, un;
   logic [15:0] req_word, in_instr;
   decode_out_t result;
   group_t g;
   int n_errors = 0;
   int compares = 0;
   logic [15:0] corner [15] = '{16'h5888, 16'h5C3F, 16'hB082, 16'hB07F, 16'h6FFF, 16'h7C1F, 16'hF7FF, 16'hF000,
      16'h4468, 16'h4640, 16'h4540, 16'h4780, 16'hDE12, 16'hE800, 16'hA9FF};
   fetch_model i_fetch_model(.clk(clk), .req_valid(req_valid), .req_word(req_word), .in_valid(in_valid),
      .in_instr(in_instr));
   compressed_instruction_decoder i_compressed_instruction_decoder(.clk(clk), .reset(reset), .in_valid(in_valid),
      .in_instr(in_instr), .result(result));
   // Core clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Format group from the fixed upper bits
   function automatic group_t grp(input logic [7:0] w);
      casez (w)
         8'b00011???: return G_ADDSUB;
         8'b000?????: return G_SHIFT;
         8'b001?????: return G_IMM;
         8'b010000??: return G_ALU;
         8'b010001??: return G_HIREG;
         8'b01001???: return G_PCLOAD;
         8'b0101??0?: return G_REGOFS;
         8'b0101????: return G_SIGNED;
         8'b011?????: return G_IMMOFS;
         8'b1000????: return G_HALF;
         8'b1001????: return G_SPREL;
         8'b1010????: return G_ADDR;
         8'b10110000: return G_SPADJ;
         8'b1011?10?: return G_PUSHPOP;
         8'b1100????: return G_MULTI;
         8'b11011111: return G_SWI;
         8'b1101????: return G_BCOND;
         8'b11100???: return G_BRANCH;
         8'b1111????: return G_LONGBL;
         default: return G_NONE;
      endcase
   endfunction
   task automatic check(input logic [39:0] seen, input logic [39:0] want);
      compares++;
      if (seen !== want) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic send(input logic v, input logic [15:0] w);
      @(posedge clk);
      req_valid <= v;
      req_word <= w;
   endtask
   task automatic complete_run;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Result against the halfword taken one edge earlier
   always @(negedge clk) begin
      g = grp(in_instr[15:8]);
      fw = in_valid && (g inside {G_SHIFT, G_ADDSUB, G_IMM, G_ALU} || (g == G_HIREG && in_instr[9:8] == 2'b01));
      un = in_valid && (g == G_NONE || (g == G_BCOND && in_instr[11:8] == 4'hE) || (g == G_HIREG && in_instr[9:7] == 3'h7));
      if (reset && $time > 15) begin
         check(result, 40'h0);
      end else if (!reset) begin
         check({result.valid, result.flags_write, result.undefined}, {in_valid, fw, un});
         if (in_valid) begin
            check(result.group, g);
            if (un) begin
               check(result.expanded, 32'hE1A00000);
            end else if (g == G_REGOFS) begin
               check(result.expanded, {8'hE7, 1'b1, in_instr[10], 1'b0, in_instr[11], 1'b0, in_instr[5:3],
                  1'b0, in_instr[2:0], 8'h00, 1'b0, in_instr[8:6]});
            end else if (g == G_IMMOFS) begin
               check(result.expanded, {8'hE5, 1'b1, in_instr[12], 1'b0, in_instr[11], 1'b0,
                  in_instr[5:3], 1'b0, in_instr[2:0], in_instr[12] ? {7'h00, in_instr[10:6]} :
                  {5'h00, in_instr[10:6], 2'b00}});
            end else if (g == G_SPADJ) begin
               check(result.expanded, {8'hE2, in_instr[7] ? 4'h4 : 4'h8, 12'hDDF, 1'b0, in_instr[6:0]});
            end else if (g == G_LONGBL) begin
               check({result.expanded[31:24], result.expanded[11:0]}, {8'hEB, in_instr[11:0]});
            end else if (g == G_SHIFT) begin
               check(result.expanded, {12'hE1B, 5'h00, in_instr[2:0], in_instr[10:6],
                  in_instr[12:11], 2'b00, in_instr[5:3]});
            end else if (g == G_MULTI) begin
               check(result.expanded, {8'hE8, 3'b101, in_instr[11], 1'b0, in_instr[10:8],
                  8'h00, in_instr[7:0]});
            end else if (g == G_BCOND) begin
               check(result.expanded, {in_instr[11:8], 4'hA, {16{in_instr[7]}}, in_instr[7:0]});
            end else if (g == G_BRANCH) begin
               check(result.expanded, {8'hEA, {13{in_instr[10]}}, in_instr[10:0]});
            end else if (g == G_SWI) begin
               check(result.expanded, {16'hEF00, 8'h00, in_instr[7:0]});
            end
         end
      end
   end
   // Corner halfwords, random traffic, a reset in mid-run
   initial begin
      reset = 1'b1;
      req_valid = 1'b0;
      req_word = 16'h0000;
      void'($urandom(6));
      repeat (16) @(negedge clk);
      reset <= 1'b0;
      foreach (corner[i]) send(1'b1, corner[i]);
      repeat (1500) send($urandom_range(3) != 0, 16'($urandom));
      @(negedge clk);
      reset <= 1'b1;
      repeat (3) @(negedge clk);
      reset <= 1'b0;
      repeat (1500) send($urandom_range(3) != 0, 16'($urandom));
      send(1'b0, 16'h0000);
      repeat (3) @(posedge clk);
      complete_run;
   end
   // Watchdog
   initial begin
      #200000;
      n_errors++;
      complete_run;
   end
endmodule
`default_nettype wire
